// *** src/wcsc_det_if.sv ***
// Interface carrying detector results from the input monitor to the controller.
// Assumes both ends sit on mclk.
`timescale 1ns/1ns
interface wcsc_det_if;
  import wcsc_pkg::*;
  logic valid; // Stable word clock present
  logic edge_seen; // One-cycle pulse on each rising input edge
  logic [CNT_W-1:0] period; // Measured input period in mclk cycles
  wcsc_speed_type speed; // Detected speed class
  modport mon (output valid, output edge_seen, output period, output speed);
  modport ctl (input valid, input edge_seen, input period, input speed);
endinterface : wcsc_det_if

// *** src/wcsc_in_monitor.sv ***
// Word clock input monitor: measures the period, judges validity and speed.
// Assumes word_clock_in is already synchronous to mclk.
`timescale 1ns/1ns
module wcsc_in_monitor
  import wcsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Word clock input level
  input wire logic word_clock_in,
  // Results
  wcsc_det_if.mon det
);
  // All state in one record
  typedef struct packed {
    logic prev; // Last input level
    logic [CNT_W-1:0] cnt; // Cycles since last rising edge
    logic [CNT_W-1:0] period; // Last full period
    logic [3:0] good; // Consecutive matching periods
    logic valid; // Stable signal present
    wcsc_speed_type speed; // Speed class
  } wcsc_mon_type;

  wcsc_mon_type r;
  wcsc_mon_type next_r;
  logic rise;
  logic [CNT_W-1:0] diff;

  // Period limits for validity and speed classes, in cycles; lock edge count
  localparam logic [CNT_W-1:0] LIM_LOSS = CNT_W'(LOSS_CYC);
  localparam logic [CNT_W-1:0] LIM_FAST = CNT_W'(FAST_CYC);
  localparam logic [CNT_W-1:0] LIM_SGL = CNT_W'(MCLK_HZ / SINGLE_MAX_HZ);
  localparam logic [CNT_W-1:0] LIM_DBL = CNT_W'(MCLK_HZ / DOUBLE_MAX_HZ);
  localparam logic [3:0] GOOD_MAX = 4'(LOCK_EDGES);

  // Edge and period-match helpers
  assign rise = word_clock_in & ~r.prev;
  assign diff = (r.cnt > r.period) ? (r.cnt - r.period) : (r.period - r.cnt);

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.prev = word_clock_in;
    next_r.cnt = (r.cnt == LIM_LOSS) ? r.cnt : r.cnt + CNT_W'(1);
    if (rise) begin
      next_r.cnt = CNT_W'(1);
      next_r.period = r.cnt;
      // Period must be stable and inside the legal range
      if (diff <= CNT_W'(PER_TOL) && r.cnt >= LIM_FAST && r.cnt < LIM_LOSS) begin
        if (r.good != GOOD_MAX) begin
          next_r.good = r.good + 4'(1);
        end
      end else begin
        next_r.good = '0;
      end
      // Automatic speed class from the period
      if (r.cnt > LIM_SGL) begin
        next_r.speed = WCSC_SPEED_SINGLE;
      end else if (r.cnt > LIM_DBL) begin
        next_r.speed = WCSC_SPEED_DOUBLE;
      end else begin
        next_r.speed = WCSC_SPEED_QUAD;
      end
    end
    // Timeout kills validity at once
    if (r.cnt == LIM_LOSS) begin
      next_r.good = '0;
    end
    next_r.valid = (next_r.good == GOOD_MAX);
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign det.valid = r.valid;
  assign det.edge_seen = rise;
  assign det.period = r.period;
  assign det.speed = r.speed;

  // Validity drops when no edge arrives within the loss window
  a_loss_drop: assert property (@(posedge mclk) disable iff (rst)
    (r.cnt == LIM_LOSS) |=> !r.valid) else $error("Valid held after timeout");
endmodule : wcsc_in_monitor

// *** src/wcsc_pkg.sv ***
// Package for the word clock sync control block: modes, rates, timing counts.
// Assumes a single 25 MHz mclk domain; all other rates are enable pulses.
package wcsc_pkg;
  // Clock rate in Hz
  localparam int unsigned MCLK_HZ = 25_000_000;
  // Standard base rates in Hz
  localparam int unsigned RATE_32K = 32_000;
  localparam int unsigned RATE_441K = 44_100;
  localparam int unsigned RATE_48K = 48_000;
  localparam int unsigned RATE_96K = 96_000;
  // Speed class limits: single up to 56k, double up to 112k, else quad
  localparam int unsigned SINGLE_MAX_HZ = 56_000;
  localparam int unsigned DOUBLE_MAX_HZ = 112_000;
  // Slowest legal input 32 kHz less margin: period limit in cycles
  localparam int unsigned LOSS_MIN_HZ = 24_000;
  localparam int unsigned LOSS_CYC = MCLK_HZ / LOSS_MIN_HZ;
  // Fastest legal input (quad 192k plus margin)
  localparam int unsigned FAST_MAX_HZ = 220_000;
  localparam int unsigned FAST_CYC = MCLK_HZ / FAST_MAX_HZ;
  // Edges of matching period before lock is declared
  localparam int unsigned LOCK_EDGES = 4;
  // Lock-to-sync promotion after further stable edges
  localparam int unsigned SYNC_EDGES = 16;
  // Period tolerance in cycles for stable input
  localparam int unsigned PER_TOL = 4;
  // Regenerated internal clock, about 22 MHz (512 x 44.1k)
  localparam int unsigned REGEN_MULT = 512;
  // Internal phase accumulator width
  localparam int unsigned ACC_W = 32;
  // Counter width
  localparam int unsigned CNT_W = 12;
  // Phase step scaling: step = rate * 2^32 / mclk
  localparam longint unsigned ACC_ONE = 64'h0000_0001_0000_0000;

  // Speed classes of the input
  typedef enum logic [1:0] {
    WCSC_SPEED_SINGLE = 2'h0,
    WCSC_SPEED_DOUBLE = 2'h1,
    WCSC_SPEED_QUAD = 2'h2
  } wcsc_speed_type;

  // Sync status shown to the host
  typedef enum logic [1:0] {
    WCSC_STAT_NONE = 2'h0,
    WCSC_STAT_LOCK = 2'h1,
    WCSC_STAT_SYNC = 2'h2
  } wcsc_stat_type;

  // Clock source selection
  typedef enum logic [1:0] {
    WCSC_SRC_INTERNAL = 2'h0,
    WCSC_SRC_WORD = 2'h1,
    WCSC_SRC_OTHER = 2'h2
  } wcsc_src_type;
endpackage : wcsc_pkg

// *** src/wcsc_top.sv ***
// Word clock sync control: source choice, lock status, output clock synthesis.
// Assumes host settings are static-ish levels sampled on mclk; input is mclk-synchronous.
`timescale 1ns/1ns
module wcsc_top
  import wcsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Word clock pins
  input wire logic word_clock_in,
  output logic word_clock_out,
  output logic word_clock_term,
  // Host configuration
  input wire logic cfg_slave,
  input wire wcsc_src_type cfg_source,
  input wire logic [17:0] cfg_rate_hz,
  input wire logic cfg_single_speed,
  input wire logic cfg_term,
  // Other clock input reference (already detected elsewhere)
  input wire logic other_ref_valid,
  input wire logic [17:0] other_ref_hz,
  // Status
  output logic word_clock_lock_led,
  output wcsc_stat_type sync_status,
  output logic slave_active,
  output logic fallback_event,
  output wcsc_speed_type in_speed,
  output logic [17:0] out_rate_hz,
  output logic regen_clk_en
);
  wcsc_det_if det();

  // Input monitor
  wcsc_in_monitor u_mon (
    .mclk(mclk),
    .rst(rst),
    .word_clock_in(word_clock_in),
    .det(det)
  );

  // All controller state in one record
  typedef struct packed {
    logic slave; // Currently slaved
    logic [17:0] fb_hz; // Fallback master rate
    logic fb_hold; // Master forced after loss
    logic [4:0] sync_cnt; // Edges since lock
    wcsc_stat_type stat; // Host status
    logic led; // Lock LED
    logic [ACC_W-1:0] acc; // Output phase accumulator
    logic [ACC_W-1:0] racc; // Regenerated clock accumulator
    logic wco; // Output word clock level
    logic regen; // Regenerated clock enable
    logic [17:0] rate; // Rate carried on the output
    logic fb_pulse; // Fallback event pulse
    logic term; // Termination control
  } wcsc_ctl_type;

  wcsc_ctl_type r;
  wcsc_ctl_type next_r;

  localparam logic [4:0] SYNC_MAX = 5'(SYNC_EDGES);
  localparam logic [17:0] HZ_441 = 18'(RATE_441K);
  localparam logic [17:0] HZ_48 = 18'(RATE_48K);
  localparam logic [17:0] HZ_96 = 18'(RATE_96K);
  localparam logic [17:0] HZ_32 = 18'(RATE_32K);
  // Fallback candidates: the three base rates at single, double and quad speed
  localparam int BASE_N = 3;
  localparam int SPEED_N = 3;
  localparam logic [BASE_N-1:0][17:0] BASE_HZ = {HZ_48, HZ_441, HZ_32};

  logic word_use; // Word input in use as reference
  logic ref_ok; // Current slave reference valid
  logic [17:0] ref_hz; // Rate of selected slave reference
  logic [17:0] meas_hz; // Word input rate from period
  logic [17:0] tgt_hz; // Rate before single-speed division
  logic [17:0] div_hz; // Rate after single-speed division
  logic [ACC_W-1:0] step; // Output accumulator step
  logic [ACC_W-1:0] rstep; // Regen accumulator step
  logic [ACC_W:0] rsum; // Regen sum with carry
  logic [17:0] near_hz; // Standard rate closest to the rate carried
  logic [17:0] near_dist; // Distance to that rate
  logic [17:0] cand_hz; // Candidate standard rate
  logic [17:0] cand_dist; // Distance to the candidate

  // Input rate estimate from measured period
  always_comb begin
    meas_hz = (det.period == '0) ? HZ_48 : 18'(MCLK_HZ / det.period);
  end

  // Reference choice and rate target
  always_comb begin
    word_use = (cfg_source == WCSC_SRC_WORD) && det.valid;
    ref_ok = (cfg_source == WCSC_SRC_WORD) ? det.valid : other_ref_valid;
    ref_hz = (cfg_source == WCSC_SRC_WORD) ? meas_hz : other_ref_hz;
    if (r.slave) begin
      tgt_hz = ref_hz;
    end else if (r.fb_hold) begin
      tgt_hz = r.fb_hz;
    end else begin
      tgt_hz = cfg_rate_hz;
    end
    // Quarter above 96k, else halve above 48k; never below 32k
    div_hz = tgt_hz;
    if (cfg_single_speed) begin
      if (div_hz > HZ_96) begin
        div_hz = div_hz >> 2;
      end else if (div_hz > HZ_48) begin
        div_hz = div_hz >> 1;
      end
      if (div_hz < HZ_32) begin
        div_hz = HZ_32;
      end
    end
    // Phase steps; product kept in 64 bits before scaling
    step = ACC_W'((64'(div_hz) * ACC_ONE) / 64'(MCLK_HZ));
    rstep = ACC_W'((64'(tgt_hz) * 64'(REGEN_MULT) * ACC_ONE) / 64'(MCLK_HZ));
    rsum = {1'b0, r.racc} + {1'b0, rstep};
  end

  // Nearest standard rate for fallback; a measured rate is never exact, so match by distance
  always_comb begin
    near_hz = HZ_48;
    near_dist = '1;
    cand_hz = '0;
    cand_dist = '0;
    for (int s = 0; s < SPEED_N; s++) begin
      for (int b = 0; b < BASE_N; b++) begin
        cand_hz = BASE_HZ[b] << s;
        cand_dist = (r.rate > cand_hz) ? (r.rate - cand_hz) : (cand_hz - r.rate);
        // First closest wins a tie
        if (cand_dist < near_dist) begin
          near_dist = cand_dist;
          near_hz = cand_hz;
        end
      end
    end
  end

  // Controller next state
  always_comb begin
    next_r = r;
    next_r.fb_pulse = 1'b0;
    next_r.term = cfg_term;
    // Leaving slave mode by host clears forced master
    if (!cfg_slave) begin
      next_r.fb_hold = 1'b0;
    end
    if (cfg_slave && !r.slave && ref_ok && !r.fb_hold) begin
      next_r.slave = 1'b1;
    end
    if (r.slave && (!ref_ok || !cfg_slave)) begin
      next_r.slave = 1'b0;
      if (cfg_slave) begin
        // Snap to nearest standard family rate
        next_r.fb_hold = 1'b1;
        next_r.fb_pulse = 1'b1;
        next_r.fb_hz = near_hz;
      end
    end
    // Clear forced master once reference returns
    if (r.fb_hold && ref_ok) begin
      next_r.fb_hold = 1'b0;
    end
    // Lock LED and lock/sync status follow word input validity, whatever the source
    if (det.valid) begin
      next_r.led = 1'b1;
      // Sync only counts while the word input is the reference in use
      if (!(r.slave && word_use)) begin
        next_r.sync_cnt = '0;
      end else if (det.edge_seen && r.sync_cnt != SYNC_MAX) begin
        next_r.sync_cnt = r.sync_cnt + 5'(1);
      end
      next_r.stat = (r.sync_cnt == SYNC_MAX && r.slave && word_use) ? WCSC_STAT_SYNC : WCSC_STAT_LOCK;
    end else begin
      next_r.led = 1'b0;
      next_r.stat = WCSC_STAT_NONE;
      next_r.sync_cnt = '0;
    end
    next_r.rate = tgt_hz;
    // Output clock; slaved to word input it realigns on each input edge
    if (r.slave && word_use && det.edge_seen) begin
      next_r.acc = step;
      next_r.wco = 1'b1;
    end else begin
      next_r.acc = r.acc + step;
      next_r.wco = ~next_r.acc[ACC_W-1];
    end
    // Regenerated high-rate clock enable, filtered by the accumulator
    next_r.racc = rsum[ACC_W-1:0];
    next_r.regen = rsum[ACC_W];
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '{slave: 1'b0, fb_hz: HZ_48, fb_hold: 1'b0, sync_cnt: '0, stat: WCSC_STAT_NONE,
             led: 1'b0, acc: '0, racc: '0, wco: 1'b0, regen: 1'b0, rate: HZ_48,
             fb_pulse: 1'b0, term: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs from flip-flops
  assign word_clock_out = r.wco;
  assign word_clock_term = r.term;
  assign word_clock_lock_led = r.led;
  assign sync_status = r.stat;
  assign slave_active = r.slave;
  assign fallback_event = r.fb_pulse;
  assign in_speed = det.speed;
  assign out_rate_hz = r.rate;
  assign regen_clk_en = r.regen;

  // Checks
  a_word_gate: assert property (@(posedge mclk) disable iff (rst)
    (cfg_source == WCSC_SRC_WORD && !det.valid && !r.slave) |=> !slave_active)
    else $error("Invalid word input used");
  a_lock_led: assert property (@(posedge mclk) disable iff (rst)
    det.valid |=> word_clock_lock_led) else $error("LED dark with valid input");
  a_led_status: assert property (@(posedge mclk) disable iff (rst)
    word_clock_lock_led == (sync_status != WCSC_STAT_NONE)) else $error("LED and status disagree");
  a_loss_clear: assert property (@(posedge mclk) disable iff (rst)
    (r.slave && cfg_slave && !ref_ok) |=> (!slave_active && fallback_event)) else $error("No fallback");
  a_loss_led: assert property (@(posedge mclk) disable iff (rst)
    $fell(det.valid) |=> !word_clock_lock_led) else $error("LED kept after loss");
  a_master_rate: assert property (@(posedge mclk) disable iff (rst)
    (!r.slave && !r.fb_hold) |=> out_rate_hz == $past(cfg_rate_hz)) else $error("Master rate wrong");
  a_single_div: assert property (@(posedge mclk) disable iff (rst)
    cfg_single_speed |-> div_hz <= HZ_48) else $error("Single speed exceeds 48k");
  a_phase_align: assert property (@(posedge mclk) disable iff (rst)
    (r.slave && word_use && det.edge_seen) |=> word_clock_out) else $error("Output not in phase");
  a_term_follow: assert property (@(posedge mclk) disable iff (rst)
    cfg_term |=> word_clock_term) else $error("Termination not applied");
endmodule : wcsc_top

// *** verification/tb_wcsc_top.sv ***
// Self-checking bench for the word clock sync control block.
// Assumes a 25 MHz mclk and inputs driven 2 ns after each rising edge.
`timescale 1ns/1ns
module tb_wcsc_top;
  import wcsc_pkg::*;
  // Clock, reset and stimulus
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic [11:0] half = 12'h011b;
  logic word_clock_in, word_clock_out, word_clock_term, cfg_slave, cfg_single_speed, cfg_term;
  logic other_ref_valid, word_clock_lock_led, slave_active, fallback_event, regen_clk_en;
  logic [17:0] cfg_rate_hz, other_ref_hz, out_rate_hz;
  wcsc_src_type cfg_source;
  wcsc_stat_type sync_status;
  wcsc_speed_type in_speed;
  // Counters
  int failures = 0;
  int tests_run = 0;
  int per, n, i;
  always #20 mclk = ~mclk;
  wcsc_wc_source wcsc_wc_source_inst (.mclk(mclk), .run(run), .half(half), .wclk(word_clock_in));
  wcsc_top wcsc_top_inst (.mclk(mclk), .rst(rst), .word_clock_in(word_clock_in), .word_clock_out(word_clock_out),
    .word_clock_term(word_clock_term), .cfg_slave(cfg_slave), .cfg_source(cfg_source), .cfg_rate_hz(cfg_rate_hz),
    .cfg_single_speed(cfg_single_speed), .cfg_term(cfg_term), .other_ref_valid(other_ref_valid),
    .other_ref_hz(other_ref_hz), .word_clock_lock_led(word_clock_lock_led), .sync_status(sync_status),
    .slave_active(slave_active), .fallback_event(fallback_event), .in_speed(in_speed),
    .out_rate_hz(out_rate_hz), .regen_clk_en(regen_clk_en));
  // k clock steps, landing just after the last edge
  task step(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask : step
  // Exact compare of a design value
  task chk_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_eq
  // Compare of a measured figure against a window
  task chk_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  // Verdict and end of run
  task end_sim;
    $display("Counts: comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Bounded wait for the lock indicator to reach a level
  task wait_led(input logic lvl, input int lim);
    n = 0;
    while (word_clock_lock_led !== lvl && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, word_clock_lock_led, lvl);
      end_sim();
    end
  endtask : wait_led
  // Bounded wait until a fresh input rise is first seen
  task wait_in_rise;
    n = 0;
    while (!(word_clock_in === 1'b0) && n < 2000) begin
      step(1);
      n++;
    end
    while (!(word_clock_in === 1'b1) && n < 2000) begin
      step(1);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 2000);
      end_sim();
    end
  endtask : wait_in_rise
  // Output word clock period, rise to rise, in mclk cycles
  task meas_out(output int p);
    n = 0;
    while (!(word_clock_out === 1'b0) && n < 3000) begin step(1); n++; end
    while (!(word_clock_out === 1'b1) && n < 3000) begin step(1); n++; end
    p = 0;
    while (word_clock_out === 1'b1 && n < 3000) begin step(1); n++; p++; end
    while (word_clock_out === 1'b0 && n < 3000) begin step(1); n++; p++; end
    if (n >= 3000) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 3000);
      end_sim();
    end
  endtask : meas_out
  initial begin
    cfg_slave = 1'b0;
    cfg_source = WCSC_SRC_INTERNAL;
    cfg_rate_hz = 18'h0_BB80;
    cfg_single_speed = 1'b0;
    cfg_term = 1'b1;
    other_ref_valid = 1'b0;
    other_ref_hz = 18'h1_5888;
    step(2);
    rst = 1'b0;
    step(1);
    // Reset state and termination setting
    chk_eq(sync_status, WCSC_STAT_NONE);
    chk_eq(out_rate_hz, 32'h0000_BB80);
    chk_eq(word_clock_term, 1'b1);
    cfg_term = 1'b0;
    step(2);
    chk_eq(word_clock_term, 1'b0);
    $display("test reset done");
    // Master rates, plain and single speed
    cfg_rate_hz = 18'h1_7700;
    step(4);
    chk_eq(out_rate_hz, 32'h0001_7700);
    meas_out(per);
    chk_rng(per, 258, 263);
    cfg_rate_hz = 18'h2_EE00;
    cfg_single_speed = 1'b1;
    step(4);
    meas_out(per);
    meas_out(per);
    chk_rng(per, 519, 523);
    cfg_rate_hz = 18'h0_7D00;
    step(4);
    meas_out(per);
    meas_out(per);
    chk_rng(per, 779, 783);
    cfg_single_speed = 1'b0;
    $display("test master done");
    // Valid word clock present but source internal: stays master
    run = 1'b1;
    cfg_slave = 1'b1;
    wait_led(1'b1, 8000);
    chk_eq(sync_status, WCSC_STAT_LOCK);
    chk_eq(slave_active, 1'b0);
    // Source word: slave, lock then sync, speed single
    cfg_source = WCSC_SRC_WORD;
    step(3);
    chk_eq(slave_active, 1'b1);
    chk_eq(in_speed, WCSC_SPEED_SINGLE);
    step(17 * 566 + 40);
    chk_eq(sync_status, WCSC_STAT_SYNC);
    meas_out(per);
    chk_rng(per, 563, 569);
    // Input rise: output still low, then rises on the edge that takes the input rise
    wait_in_rise();
    chk_eq(word_clock_out, 1'b0);
    step(1);
    chk_eq(word_clock_out, 1'b1);
    // Regenerated clock enable density, 512 times 44.17 kHz over 1000 cycles
    per = 0;
    for (i = 0; i < 1000; i++) begin
      step(1);
      if (regen_clk_en === 1'b1) per++;
    end
    chk_rng(per, 895, 915);
    $display("test slave word done");
    // Loss of reference right after an input rise: fallback, status cleared together
    wait_in_rise();
    run = 1'b0;
    n = 0;
    while (fallback_event !== 1'b1 && n < 1400) begin
      step(1);
      n++;
    end
    chk_rng(n, 1000, 1399);
    if (n >= 1400) begin
      end_sim();
    end
    chk_eq(word_clock_lock_led, 1'b0);
    chk_eq(sync_status, WCSC_STAT_NONE);
    chk_eq(slave_active, 1'b0);
    step(1);
    chk_eq(out_rate_hz, 32'h0000_AC44);
    chk_eq(fallback_event, 1'b0);
    $display("test loss done");
    // Double then quad speed inputs
    half = 12'h082;
    run = 1'b1;
    wait_led(1'b1, 4000);
    chk_eq(in_speed, WCSC_SPEED_DOUBLE);
    run = 1'b0;
    wait_led(1'b0, 1500);
    half = 12'h041;
    run = 1'b1;
    wait_led(1'b1, 4000);
    chk_eq(in_speed, WCSC_SPEED_QUAD);
    $display("test speeds done");
    // Slave to the other reference
    cfg_source = WCSC_SRC_OTHER;
    other_ref_valid = 1'b1;
    step(4);
    chk_eq(slave_active, 1'b1);
    chk_eq(out_rate_hz, 32'h0001_5888);
    $display("test other source done");
    end_sim();
  end
endmodule : tb_wcsc_top

// *** verification/wcsc_wc_source.sv ***
// Partner model: an external word clock master feeding the block's input.
// Assumes mclk is the bench clock; half period is given in mclk cycles.
`timescale 1ns/1ns
module wcsc_wc_source (
  // Clock
  input wire logic mclk,
  // Control from the bench
  input wire logic run,
  input wire logic [11:0] half,
  // Word clock line
  output logic wclk
);
  // Cycle counter within one half period, and the line level
  logic [11:0] cnt = 12'h000;
  logic line = 1'b0;
  assign wclk = line;
  // Square wave only while this device is the one master; stopped line rests low
  // Changed on the edge without race, so the block takes a new level one edge later
  always @(posedge mclk) begin
    if (!run) begin
      line <= 1'b0;
      cnt <= 12'h000;
    end else if (cnt >= half - 12'h001) begin
      line <= ~line;
      cnt <= 12'h000;
    end else begin
      cnt <= cnt + 12'h001;
    end
  end
endmodule : wcsc_wc_source
